// [hw/ua_map.svh]
// Register offsets, field positions, reset values and timing counts of the serial unit
`ifndef UA_MAP_SVH
`define UA_MAP_SVH
`define UA_OFF_MODE  8'h00
`define UA_OFF_TXB   8'h04
`define UA_OFF_TXST  8'h08
`define UA_OFF_RXST  8'h0c
`define UA_OFF_RXB   8'h10
`define UA_OFF_BAUD  8'h14
`define UA_B_POWER   7
`define UA_B_TXE     6
`define UA_B_RXE     5
`define UA_B_PSH     4
`define UA_B_PSL     3
`define UA_B_CL      2
`define UA_B_SL      1
`define UA_B_ISRM    0
`define UA_MODE_RST  8'h01
`define UA_BAUD_RST  8'hff
`define UA_TX_GAP    2
`define UA_OVS       16
`endif

// [hw/ua_pkg.sv]
// State types of the serial unit
package ua_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_GAP, TX_START, TX_DATA, TX_PAR, TX_STOP} ua_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ua_rx_t;
endpackage

// [hw/ua_baud.sv]
// Baud tick generator: divider counter followed by a divide-by-two stage
`timescale 1ns/100ps
`default_nettype none
module ua_baud #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             restart,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_ff, nxt_cnt;
  logic             half_ff, nxt_half;
  logic             tick_ff, nxt_tick;

  if (DIV_W < 2) begin : g_bad
    $error("ua_baud: DIV_W too small");
  end

  always_comb begin
    nxt_cnt  = cnt_ff + 1'b1;
    nxt_half = half_ff;
    nxt_tick = 1'b0;
    if (restart) begin
      nxt_cnt  = '0;
      nxt_half = 1'b0;
    end else if (cnt_ff == div) begin
      nxt_cnt  = '0;
      nxt_half = ~half_ff;
      nxt_tick = half_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff  <= '0;
      half_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      half_ff <= nxt_half;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

  // Helper: cycles since the last tick, valid only while div stays put
  logic [DIV_W+1:0] gap_ff;
  logic             seen_ff;
  logic [DIV_W-1:0] div_q;
  always_ff @(posedge clk) begin
    div_q   <= div;
    gap_ff  <= (tick_ff || restart) ? '0 : gap_ff + 1'b1;
    seen_ff <= (srst || restart || div != div_q) ? 1'b0 : (tick_ff ? 1'b1 : seen_ff);
  end

  chk_tick_period: assert property (@(posedge clk) disable iff (srst)
    tick_ff && seen_ff && div == div_q |-> gap_ff == {1'b0, div, 1'b1})
    else $error("baud tick period is not twice the divider period");
endmodule
`default_nettype wire

// [hw/ua_uart.sv]
// Asynchronous serial transceiver with APB register access
// Operation
// - With clock stopped all registers freeze; with clock running operation continues.
// - Serial output keeps its last level while the clock is stopped.
// - Back-to-back frames get two extra clock cycles between stop and start.
// - Receiver restarts its bit timing on every detected start bit.
// - Enabling reception while the input is low starts a reception.
// - Receiver always uses one stop bit and ignores a second one.
// - Parity error flag follows the selected parity mode.
// - Only the first bit after data and parity is checked as stop bit.
// - While an overrun error stands the next character is discarded.
// - Bit rate is the eight-bit divider output divided by two, then by OVS ticks per bit.
`include "ua_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ua_uart #(
  parameter int OVS = `UA_OVS
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_input_pin,
  output logic             serial_output_pin,
  output logic             tx_done,
  output logic             rx_done,
  output logic             rx_error
);
  localparam int TW = $clog2(OVS);
  localparam logic [TW-1:0] TK_LAST = TW'(OVS - 1);
  localparam logic [TW-1:0] TK_MID  = TW'(OVS / 2 - 1);

  if (OVS < 4 || (OVS & (OVS - 1)) != 0) begin : g_bad
    $error("ua_uart: OVS must be a power of two, at least 4");
  end

  // Register group
  logic [7:0]  mode_ff, nxt_mode, baud_ff, nxt_baud, txb_ff, nxt_txb, rxb_ff, nxt_rxb;
  logic        txb_full_ff, nxt_txb_full, rx_full_ff, nxt_rx_full;
  logic        pe_ff, nxt_pe, fe_ff, nxt_fe, ov_ff, nxt_ov;
  logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  // Transmit group
  ua_pkg::ua_tx_t tx_st_ff, nxt_tx_st;
  logic [TW-1:0]  tx_tk_ff, nxt_tx_tk;
  logic [2:0]     tx_bit_ff, nxt_tx_bit;
  logic [7:0]     tx_sh_ff, nxt_tx_sh;
  logic           tx_par_ff, nxt_tx_par, tx_stp_ff, nxt_tx_stp, txd_ff, nxt_txd;
  logic           tx_gap_ff, nxt_tx_gap, tx_done_ff, nxt_tx_done, tx_load, tx_tick;
  // Receive group
  ua_pkg::ua_rx_t rx_st_ff, nxt_rx_st;
  logic [TW-1:0]  rx_tk_ff, nxt_rx_tk;
  logic [2:0]     rx_bit_ff, nxt_rx_bit;
  logic [7:0]     rx_sh_ff, nxt_rx_sh, rx_char;
  logic           rx_par_ff, nxt_rx_par, rx_done_ff, nxt_rx_done, rx_err_ff, nxt_rx_err;
  logic           rx_fin, rx_pe, rx_fe, rx_ovr, rx_restart, rx_tick;
  logic           sin_meta_ff, sin_ff;

  wire       run_tx = mode_ff[`UA_B_POWER] & mode_ff[`UA_B_TXE];
  wire       run_rx = mode_ff[`UA_B_POWER] & mode_ff[`UA_B_RXE];
  wire       par_on = mode_ff[`UA_B_PSH] | mode_ff[`UA_B_PSL];
  wire [2:0] last_bit = mode_ff[`UA_B_CL] ? 3'h7 : 3'h6;
  wire       acc = psel & penable & pready_ff;
  wire       tx_busy = tx_st_ff != ua_pkg::TX_IDLE;

  ua_baud #(.DIV_W(8)) u_tx_baud (
    .clk     (clk),
    .srst    (srst),
    .restart (tx_load),
    .div     (baud_ff),
    .tick    (tx_tick)
  );

  ua_baud #(.DIV_W(8)) u_rx_baud (
    .clk     (clk),
    .srst    (srst),
    .restart (rx_restart),
    .div     (baud_ff),
    .tick    (rx_tick)
  );

  always_comb begin
    nxt_mode     = mode_ff;
    nxt_baud     = baud_ff;
    nxt_txb      = txb_ff;
    nxt_txb_full = txb_full_ff & ~tx_load;
    nxt_rxb      = rxb_ff;
    nxt_rx_full  = rx_full_ff;
    nxt_pe       = pe_ff;
    nxt_fe       = fe_ff;
    nxt_ov       = ov_ff;
    nxt_pready   = psel & penable & ~pready_ff;
    nxt_prdata   = prdata_ff;
    nxt_pslverr  = pslverr_ff;
    if (nxt_pready) begin
      nxt_prdata  = 32'h0;
      nxt_pslverr = 1'b0;
      case (paddr)
        `UA_OFF_MODE: nxt_prdata = {24'h0, mode_ff};
        `UA_OFF_TXB:  nxt_prdata = {24'h0, txb_ff};
        `UA_OFF_TXST: nxt_prdata = {30'h0, txb_full_ff, tx_busy};
        `UA_OFF_RXST: nxt_prdata = {29'h0, pe_ff, fe_ff, ov_ff};
        `UA_OFF_RXB:  nxt_prdata = {24'h0, rxb_ff};
        `UA_OFF_BAUD: nxt_prdata = {24'h0, baud_ff};
        default:      nxt_pslverr = 1'b1;
      endcase
    end
    if (acc && pwrite) begin
      case (paddr)
        `UA_OFF_MODE: nxt_mode = pwdata[7:0];
        `UA_OFF_BAUD: nxt_baud = pwdata[7:0];
        `UA_OFF_TXB: begin
          // A write into a full buffer is dropped rather than corrupting the queued character
          if (run_tx && !txb_full_ff) begin
            nxt_txb      = pwdata[7:0];
            nxt_txb_full = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (acc && !pwrite && paddr == `UA_OFF_RXST) begin
      nxt_pe = 1'b0;
      nxt_fe = 1'b0;
      nxt_ov = 1'b0;
    end
    if (acc && !pwrite && paddr == `UA_OFF_RXB) begin
      nxt_rx_full = 1'b0;
    end
    // Frame end after the clears, so a new error is never lost
    if (rx_fin) begin
      if (rx_ovr) begin
        nxt_ov = 1'b1;
      end else begin
        nxt_rxb     = rx_char;
        nxt_rx_full = 1'b1;
        nxt_pe      = pe_ff | rx_pe;
        nxt_fe      = fe_ff | rx_fe;
      end
    end
    if (!mode_ff[`UA_B_POWER]) begin
      nxt_txb_full = 1'b0;
      nxt_rx_full  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_ff     <= `UA_MODE_RST;
      baud_ff     <= `UA_BAUD_RST;
      txb_ff      <= 8'h00;
      txb_full_ff <= 1'b0;
      rxb_ff      <= 8'h00;
      rx_full_ff  <= 1'b0;
      pe_ff       <= 1'b0;
      fe_ff       <= 1'b0;
      ov_ff       <= 1'b0;
      pready_ff   <= 1'b0;
      prdata_ff   <= 32'h0;
      pslverr_ff  <= 1'b0;
    end else begin
      mode_ff     <= nxt_mode;
      baud_ff     <= nxt_baud;
      txb_ff      <= nxt_txb;
      txb_full_ff <= nxt_txb_full;
      rxb_ff      <= nxt_rxb;
      rx_full_ff  <= nxt_rx_full;
      pe_ff       <= nxt_pe;
      fe_ff       <= nxt_fe;
      ov_ff       <= nxt_ov;
      pready_ff   <= nxt_pready;
      prdata_ff   <= nxt_prdata;
      pslverr_ff  <= nxt_pslverr;
    end
  end

  // Transmitter
  always_comb begin
    nxt_tx_st   = tx_st_ff;
    nxt_tx_tk   = tx_tk_ff;
    nxt_tx_bit  = tx_bit_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_tx_par  = tx_par_ff;
    nxt_tx_stp  = tx_stp_ff;
    nxt_tx_gap  = 1'b0;
    nxt_txd     = txd_ff;
    nxt_tx_done = 1'b0;
    tx_load     = 1'b0;
    if (!run_tx) begin
      nxt_tx_st = ua_pkg::TX_IDLE;
      nxt_txd   = 1'b1;
    end else begin
      unique case (tx_st_ff)
        ua_pkg::TX_IDLE: tx_load = txb_full_ff;
        ua_pkg::TX_GAP: begin
          nxt_tx_gap = 1'b1;
          tx_load    = tx_gap_ff;
        end
        ua_pkg::TX_START, ua_pkg::TX_DATA, ua_pkg::TX_PAR, ua_pkg::TX_STOP: begin
          if (tx_tick) begin
            nxt_tx_tk = tx_tk_ff + 1'b1;
          end
          if (tx_tick && tx_tk_ff == TK_LAST) begin
            unique case (tx_st_ff)
              ua_pkg::TX_START: begin
                nxt_tx_st  = ua_pkg::TX_DATA;
                nxt_tx_bit = 3'h0;
                nxt_txd    = tx_sh_ff[0];
              end
              ua_pkg::TX_DATA: begin
                nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
                nxt_tx_bit = tx_bit_ff + 1'b1;
                nxt_txd    = tx_sh_ff[1];
                if (tx_bit_ff == last_bit) begin
                  nxt_tx_st = par_on ? ua_pkg::TX_PAR : ua_pkg::TX_STOP;
                  nxt_txd   = par_on ? tx_par_ff : 1'b1;
                end
              end
              ua_pkg::TX_PAR: begin
                nxt_tx_st = ua_pkg::TX_STOP;
                nxt_txd   = 1'b1;
              end
              default: begin
                nxt_tx_stp = 1'b0;
                if (!tx_stp_ff) begin
                  nxt_tx_done = 1'b1;
                  nxt_tx_st   = txb_full_ff ? ua_pkg::TX_GAP : ua_pkg::TX_IDLE;
                end
              end
            endcase
          end
        end
      endcase
    end
    if (tx_load) begin
      nxt_tx_st  = ua_pkg::TX_START;
      nxt_tx_tk  = '0;
      nxt_tx_sh  = mode_ff[`UA_B_CL] ? txb_ff : {1'b0, txb_ff[6:0]};
      nxt_tx_par = mode_ff[`UA_B_PSH] & (mode_ff[`UA_B_PSL] ~^ (^nxt_tx_sh));
      nxt_tx_stp = mode_ff[`UA_B_SL];
      nxt_txd    = 1'b0;
    end
  end

  // Plain flops keep the line level whenever the clock stops
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_st_ff   <= ua_pkg::TX_IDLE;
      tx_tk_ff   <= '0;
      tx_bit_ff  <= 3'h0;
      tx_sh_ff   <= 8'h00;
      tx_par_ff  <= 1'b0;
      tx_stp_ff  <= 1'b0;
      tx_gap_ff  <= 1'b0;
      txd_ff     <= 1'b1;
      tx_done_ff <= 1'b0;
    end else begin
      tx_st_ff   <= nxt_tx_st;
      tx_tk_ff   <= nxt_tx_tk;
      tx_bit_ff  <= nxt_tx_bit;
      tx_sh_ff   <= nxt_tx_sh;
      tx_par_ff  <= nxt_tx_par;
      tx_stp_ff  <= nxt_tx_stp;
      tx_gap_ff  <= nxt_tx_gap;
      txd_ff     <= nxt_txd;
      tx_done_ff <= nxt_tx_done;
    end
  end

  // Receiver
  always_comb begin
    nxt_rx_st   = rx_st_ff;
    nxt_rx_tk   = rx_tk_ff;
    nxt_rx_bit  = rx_bit_ff;
    nxt_rx_sh   = rx_sh_ff;
    nxt_rx_par  = rx_par_ff;
    rx_restart  = 1'b0;
    rx_fin      = 1'b0;
    rx_char     = mode_ff[`UA_B_CL] ? rx_sh_ff : {1'b0, rx_sh_ff[7:1]};
    rx_fe       = ~sin_ff;
    rx_pe       = mode_ff[`UA_B_PSH] & (rx_par_ff ^ (mode_ff[`UA_B_PSL] ~^ (^rx_char)));
    rx_ovr      = rx_full_ff | ov_ff;
    if (!run_rx) begin
      nxt_rx_st = ua_pkg::RX_IDLE;
    end else begin
      unique case (rx_st_ff)
        ua_pkg::RX_IDLE: begin
          // Level, not edge: a low line at enable starts a frame
          if (!sin_ff) begin
            rx_restart = 1'b1;
            nxt_rx_st  = ua_pkg::RX_START;
            nxt_rx_tk  = '0;
          end
        end
        ua_pkg::RX_START: begin
          if (rx_tick) begin
            nxt_rx_tk = rx_tk_ff + 1'b1;
            if (rx_tk_ff == TK_MID) begin
              nxt_rx_tk  = '0;
              nxt_rx_bit = 3'h0;
              nxt_rx_st  = sin_ff ? ua_pkg::RX_IDLE : ua_pkg::RX_DATA;
            end
          end
        end
        ua_pkg::RX_DATA, ua_pkg::RX_PAR, ua_pkg::RX_STOP: begin
          if (rx_tick) begin
            nxt_rx_tk = rx_tk_ff + 1'b1;
          end
          if (rx_tick && rx_tk_ff == TK_LAST) begin
            unique case (rx_st_ff)
              ua_pkg::RX_DATA: begin
                nxt_rx_sh  = {sin_ff, rx_sh_ff[7:1]};
                nxt_rx_bit = rx_bit_ff + 1'b1;
                if (rx_bit_ff == last_bit) begin
                  nxt_rx_st = par_on ? ua_pkg::RX_PAR : ua_pkg::RX_STOP;
                end
              end
              ua_pkg::RX_PAR: begin
                nxt_rx_par = sin_ff;
                nxt_rx_st  = ua_pkg::RX_STOP;
              end
              default: begin
                // One stop bit checked; a second one just looks like idle line
                rx_fin    = 1'b1;
                nxt_rx_st = ua_pkg::RX_IDLE;
              end
            endcase
          end
        end
      endcase
    end
    nxt_rx_err  = rx_fin & (rx_ovr | rx_pe | rx_fe);
    nxt_rx_done = rx_fin & (~nxt_rx_err | mode_ff[`UA_B_ISRM]);
  end

  always_ff @(posedge clk) begin
    sin_meta_ff <= serial_input_pin;
    sin_ff      <= sin_meta_ff;
    if (srst) begin
      rx_st_ff   <= ua_pkg::RX_IDLE;
      rx_tk_ff   <= '0;
      rx_bit_ff  <= 3'h0;
      rx_sh_ff   <= 8'h00;
      rx_par_ff  <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_err_ff  <= 1'b0;
    end else begin
      rx_st_ff   <= nxt_rx_st;
      rx_tk_ff   <= nxt_rx_tk;
      rx_bit_ff  <= nxt_rx_bit;
      rx_sh_ff   <= nxt_rx_sh;
      rx_par_ff  <= nxt_rx_par;
      rx_done_ff <= nxt_rx_done;
      rx_err_ff  <= nxt_rx_err;
    end
  end

  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign serial_output_pin = txd_ff;
  assign tx_done           = tx_done_ff;
  assign rx_done           = rx_done_ff;
  assign rx_error          = rx_err_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_gap_enter;
    tx_st_ff == ua_pkg::TX_GAP && $past(tx_st_ff) != ua_pkg::TX_GAP;
  endsequence
  // Two gap clocks with the line high, then the start bit
  sequence s_gap_start;
    serial_output_pin ##1 serial_output_pin ##1 (tx_st_ff == ua_pkg::TX_START && !serial_output_pin);
  endsequence

  chk_gap_two_clocks: assert property ((s_gap_enter and run_tx) |-> s_gap_start)
    else $error("continuous gap is not two clocks");
  chk_start_restart: assert property (rx_st_ff == ua_pkg::RX_IDLE && run_rx && !sin_ff
    |=> rx_st_ff == ua_pkg::RX_START && rx_tk_ff == '0)
    else $error("start bit did not restart receive timing");
  chk_enable_low_line: assert property ($rose(run_rx) && !sin_ff && rx_st_ff == ua_pkg::RX_IDLE
    |=> rx_st_ff == ua_pkg::RX_START)
    else $error("enable on low line did not start reception");
  chk_frame_error: assert property (rx_fin && !rx_ovr && !sin_ff |=> fe_ff && rx_err_ff)
    else $error("bad first stop bit not flagged");
  chk_single_stop: assert property (rx_fin |=> rx_st_ff != ua_pkg::RX_STOP)
    else $error("receiver waited for a second stop bit");
  chk_overrun_drop: assert property (rx_fin && rx_ovr |=> ov_ff && $stable(rxb_ff))
    else $error("character loaded during overrun");
  chk_no_parity: assert property (rx_fin && !mode_ff[`UA_B_PSH] |=> !$rose(pe_ff))
    else $error("parity error raised with parity check off");
  chk_tx_done_once: assert property (tx_done_ff |-> serial_output_pin ##1 !tx_done_ff)
    else $error("transmit completion not a single pulse at stop");
  chk_line_hold: assert property (!run_tx && !$past(run_tx) |-> serial_output_pin ##1 $stable(serial_output_pin))
    else $error("output line moved while transmitter is off");
endmodule
`default_nettype wire

// [verification/ua_remote.sv]
// Remote serial node: sends frames to the unit and decodes the frames it sends
`timescale 1ns/100ps
`default_nettype none
module ua_remote #(
  parameter int BIT = 8
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  int         hi_run = 0;
  int         gap    = 0;
  int         cnt    = 0;
  logic [7:0] got    = 8'h00;
  logic [7:0] prev   = 8'h00;
  logic [7:0] sh;

  initial line_out = 1'b1;

  // Length of the high run just before each start edge
  always @(posedge clk) begin
    hi_run = line_in ? hi_run + 1 : 0;
  end

  // Timing restarts at every start edge, so a stretched gap does no harm
  always begin
    @(negedge line_in);
    gap = hi_run;
    repeat (BIT / 2) @(posedge clk);
    repeat (8) begin
      repeat (BIT) @(posedge clk);
      sh = {line_in, sh[7:1]};
    end
    repeat (BIT) @(posedge clk);
    prev = got;
    got  = sh;
    cnt++;
  end

  // Line level set by hand, e.g. held low across a receive enable
  task automatic set_line(input logic v);
    line_out <= v;
  endtask

  // Frame out: start, 8 data LSB first, optional parity, one stop level
  task automatic send(input logic [7:0] d, input int pb, input logic stp);
    int i;
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      line_out <= d[i];
      repeat (BIT) @(posedge clk);
    end
    if (pb >= 0) begin
      line_out <= pb[0];
      repeat (BIT) @(posedge clk);
    end
    line_out <= stp;
    repeat (BIT) @(posedge clk);
    // Idle line is pulled high
    line_out <= 1'b1;
    repeat (2 * BIT) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [verification/ua_uart_tb.sv]
// Self-checking bench of the serial unit: registers, frame timing and receive errors
`timescale 1ns/100ps
`default_nettype none
`include "ua_map.svh"
module ua_uart_tb;
  localparam int OVS = 4;
  // Baud divider 0 gives a tick every 2 clocks
  localparam int BIT = 2 * OVS;
  logic        clk        = 1'b0;
  logic        srst       = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sin;
  logic        sout;
  logic        tx_done;
  logic        rx_done;
  logic        rx_error;
  int          num_errors = 0;
  int          checked    = 0;
  int          n_txd      = 0;
  int          n_rxd      = 0;
  int          n_rxe      = 0;

  ua_uart #(.OVS(OVS)) ua_uart_inst (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_input_pin(sin), .serial_output_pin(sout),
    .tx_done(tx_done), .rx_done(rx_done), .rx_error(rx_error)
  );

  ua_remote #(.BIT(BIT)) ua_remote_inst (.clk(clk), .line_in(sout), .line_out(sin));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    if (!srst) begin
      if (tx_done === 1'b1) n_txd++;
      if (rx_done === 1'b1) n_rxd++;
      if (rx_error === 1'b1) n_rxe++;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Setup, access, hold until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
    chk("pslverr", {31'h0, exp_e}, {31'h0, e});
  endtask

  task automatic t_reset();
    rdc("mode", `UA_OFF_MODE, `UA_MODE_RST, 1'b0);
    rdc("baud", `UA_OFF_BAUD, `UA_BAUD_RST, 1'b0);
    rdc("tx status", `UA_OFF_TXST, 32'h0, 1'b0);
    rdc("unmapped", 8'h1c, 32'h0, 1'b1);
  endtask

  task automatic t_tx();
    logic [31:0] r;
    logic        e;
    int          i;
    wr(`UA_OFF_BAUD, 32'h0);
    wr(`UA_OFF_MODE, 32'h85);
    wr(`UA_OFF_MODE, 32'hc5);
    wr(`UA_OFF_TXB, 32'h35);
    // Second byte only once the buffer has moved to the shifter
    i = 0;
    do begin
      apb(1'b0, `UA_OFF_TXST, 32'h0, r, e);
      i++;
    end while (r[1] !== 1'b0 && i < 50);
    wr(`UA_OFF_TXB, 32'h2a);
    for (i = 0; i < 3000 && ua_remote_inst.cnt < 2; i++) @(posedge clk);
    repeat (2 * BIT) @(posedge clk);
    chk("tx first", 32'h35, {24'h0, ua_remote_inst.prev});
    chk("tx second", 32'h2a, {24'h0, ua_remote_inst.got});
    chk("tx gap", BIT + `UA_TX_GAP, ua_remote_inst.gap);
    chk("tx_done count", 32'h2, n_txd);
    rdc("tx status idle", `UA_OFF_TXST, 32'h0, 1'b0);
    wr(`UA_OFF_MODE, 32'h85);
  endtask

  // Wrong parity bit 1 on 0x5a: only even parity flags it; two stop length set
  task automatic t_rx_parity();
    logic [31:0] m;
    int          nr;
    for (int pm = 0; pm < 4; pm++) begin
      m = 32'h87 | (32'(pm) << 3);
      wr(`UA_OFF_MODE, m);
      wr(`UA_OFF_MODE, m | 32'h20);
      nr = n_rxd;
      ua_remote_inst.send(8'h5a, pm == 0 ? -1 : 1, 1'b1);
      chk("rx_done count", nr + 1, n_rxd);
      rdc("rx status", `UA_OFF_RXST, pm == 3 ? 32'h4 : 32'h0, 1'b0);
      rdc("rx data", `UA_OFF_RXB, 32'h5a, 1'b0);
      wr(`UA_OFF_MODE, m);
    end
  endtask

  task automatic t_framing();
    logic [31:0] r;
    logic        e;
    int          ne;
    wr(`UA_OFF_MODE, 32'h87);
    wr(`UA_OFF_MODE, 32'ha7);
    ne = n_rxe;
    ua_remote_inst.send(8'h3c, -1, 1'b0);
    chk("rx_error count", ne + 1, n_rxe);
    rdc("framing", `UA_OFF_RXST, 32'h2, 1'b0);
    apb(1'b0, `UA_OFF_RXB, 32'h0, r, e);
  endtask

  task automatic t_overrun();
    int ne;
    ne = n_rxe;
    ua_remote_inst.send(8'h11, -1, 1'b1);
    ua_remote_inst.send(8'h22, -1, 1'b1);
    chk("overrun pulse", ne + 1, n_rxe);
    rdc("overrun", `UA_OFF_RXST, 32'h1, 1'b0);
    rdc("kept data", `UA_OFF_RXB, 32'h11, 1'b0);
    wr(`UA_OFF_MODE, 32'h87);
  endtask

  // Enable on a low line starts a 7-bit frame at once; release between last data and stop sample
  task automatic t_low_enable();
    int nr;
    int ne;
    wr(`UA_OFF_MODE, 32'h80);
    ua_remote_inst.set_line(1'b0);
    repeat (4) @(posedge clk);
    nr = n_rxd;
    ne = n_rxe;
    wr(`UA_OFF_MODE, 32'ha0);
    repeat (8 * BIT - 1) @(posedge clk);
    ua_remote_inst.set_line(1'b1);
    repeat (2 * BIT) @(posedge clk);
    chk("low enable rx_done", nr + 1, n_rxd);
    chk("low enable rx_error", ne, n_rxe);
    rdc("low enable status", `UA_OFF_RXST, 32'h0, 1'b0);
    rdc("low enable data", `UA_OFF_RXB, 32'h0, 1'b0);
    wr(`UA_OFF_MODE, 32'h80);
    wr(`UA_OFF_MODE, 32'h00);
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_tx();
    t_rx_parity();
    t_framing();
    t_overrun();
    t_low_enable();
    conclude();
  end

  // Whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    $display("[FAIL] watchdog expected finish seen hang");
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
